/* hw/mcs_regs.svh */
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// Clock period in nanoseconds
`define MCS_CLK_PERIOD_NS 5
// Trickle and blink period in milliseconds
`define MCS_TRICKLE_PERIOD_MS 1000
// Temperature sample interval in seconds
`define MCS_SAMPLE_PERIOD_S 16
// Hold-off is max charge time shifted by this
`define MCS_HOLDOFF_SHIFT 5
// Top-off duty: one slot in sixteen
`define MCS_TOPOFF_DUTY_BITS 4
// Reset value of chemistry flag (nickel)
`define MCS_CHEM_RESET 1'b0
`endif

/* hw/mcs_pkg.sv */
package mcs_pkg;
  // Sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    QUAL = 3'b000,
    FAST = 3'b001,
    LICV = 3'b011,
    LIDONE = 3'b010,
    TOPOFF = 3'b110,
    TRICKLE = 3'b111,
    PEND = 3'b101
  } mcs_state_type;
  // Whole state of the sequencer
  typedef struct packed {
    mcs_state_type state;
    logic lithium;
    logic [15:0] elapsed;
    logic [3:0] sampleSec;
    logic [1:0] histCount;
    logic [7:0] hist0;
    logic [7:0] hist1;
    logic prevPresent;
    logic prevWake;
    logic gate;
    logic lamp;
  } mcs_seq_type;
endpackage : mcs_pkg

/* hw/mcs_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a vector of levels
module mcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  // Both stages in one packed state
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } mcs_sync_type;
  mcs_sync_type s;
  mcs_sync_type next_s;

  // First stage only feeds the second
  always_comb begin
    next_s.stage1 = async;
    next_s.stage2 = s.stage1;
  end

  // Register the stages
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.stage2;
endmodule : mcs_sync

/* hw/mcs_tick.sv */
`timescale 1ns/1ps
// Free-running divider: count and a wrap pulse
module mcs_tick #(
  parameter int WIDTH = 28,
  parameter int PERIOD = 200_000_000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic [WIDTH-1:0] count,
  output logic tick
);
  // Counter and pulse
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } mcs_tick_type;
  mcs_tick_type s;
  mcs_tick_type next_s;
  localparam logic [WIDTH-1:0] LAST = WIDTH'(PERIOD - 1);

  // Wrap at the end of the period
  always_comb begin
    next_s.tick = (s.count == LAST);
    if (s.count == LAST) begin
      next_s.count = '0;
    end else begin
      next_s.count = s.count + 1'b1;
    end
  end

  // Register counter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign tick = s.tick;
endmodule : mcs_tick

/* hw/mcs_sequencer.sv */
`timescale 1ns/1ps
`include "mcs_regs.svh"
// Charge-cycle sequencer for a multi-chemistry charger
module mcs_sequencer #(
  // Cycles in one second, shorten for simulation
  parameter int ONE_SEC_CYCLES =
    `MCS_TRICKLE_PERIOD_MS * 1_000_000 / `MCS_CLK_PERIOD_NS,
  // Temperature code drop across two samples that ends fast charge
  parameter logic [7:0] SLOPE_DROP = 8'h04
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic batteryPresent,
  input wire logic wakeUp,
  input wire logic batteryBelowLowThreshold,
  input wire logic batteryAtMaxCellVoltage,
  input wire logic batteryBelowRechargeThreshold,
  input wire logic tempBelowHighFault,
  input wire logic tempAboveLowFault,
  input wire logic tempBelowCutoff,
  input wire logic currentBelowLimit,
  input wire logic currentBelowMinimum,
  input wire logic [7:0] temperatureLevel,
  input wire logic [15:0] maxChargeSeconds,
  input wire logic [23:0] tricklePulseCycles,
  input wire logic topOffSelect,
  output logic chargeGateOutput,
  output logic statusLampOutput
);
  localparam int IW = 10 + 8 + 16 + 24 + 1;
  localparam logic [27:0] HALF_SEC = 28'(ONE_SEC_CYCLES / 2);
  localparam logic [3:0] SAMPLE_LAST = 4'(`MCS_SAMPLE_PERIOD_S - 1);

  mcs_pkg::mcs_seq_type s;
  mcs_pkg::mcs_seq_type next_s;
  logic [IW-1:0] syncIn; // Raw pin levels
  logic [IW-1:0] syncOut; // Levels after two flops
  logic [27:0] secCount; // Position inside the second
  logic secTick; // One pulse per second

  // Synchronised copies of every input
  logic present; // Pack in the holder
  logic wake; // Leaving sleep
  logic batLow; // Below low-battery threshold
  logic batMax; // At max cell voltage
  logic batRch; // Below recharge threshold
  logic hot; // Past the high fault threshold
  logic cold; // Past the low fault threshold
  logic cutoff; // Past high-temperature cutoff
  logic iLimit; // Current under regulation target
  logic iMin; // Current under minimum
  logic [7:0] tLevel; // Temperature code
  logic [15:0] maxSec; // Programmed max charge time
  logic [23:0] pulseCyc; // Trickle pulse width
  logic topSel; // Top-off chosen

  // Derived conditions
  logic restart; // New cycle requested
  logic holdoffDone; // Slope check allowed
  logic timeUp; // Max charge time reached
  logic slopeTrip; // Temperature rising too fast
  logic sampleNow; // Sampling instant
  logic pulseOn; // Inside the trickle pulse
  logic tempOk; // Inside the temperature window

  assign syncIn = {batteryPresent, wakeUp, batteryBelowLowThreshold,
    batteryAtMaxCellVoltage, batteryBelowRechargeThreshold,
    tempBelowHighFault, tempAboveLowFault, tempBelowCutoff,
    currentBelowLimit, currentBelowMinimum, temperatureLevel,
    maxChargeSeconds, tricklePulseCycles, topOffSelect};

  // All comparator flags pass two flops
  mcs_sync #(
    .WIDTH(IW)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async(syncIn),
    .synced(syncOut)
  );

  assign {present, wake, batLow, batMax, batRch, hot, cold, cutoff,
    iLimit, iMin, tLevel, maxSec, pulseCyc, topSel} = syncOut;

  // One-second timebase
  mcs_tick #(
    .WIDTH(28),
    .PERIOD(ONE_SEC_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .count(secCount),
    .tick(secTick)
  );

  // Event and timer conditions
  always_comb begin
    restart = (present && !s.prevPresent) || (wake && !s.prevWake);
    holdoffDone = s.elapsed >= (maxSec >> `MCS_HOLDOFF_SHIFT);
    timeUp = s.elapsed >= maxSec;
    sampleNow = secTick && (s.sampleSec == SAMPLE_LAST);
    slopeTrip = sampleNow && (s.histCount == 2'd2) && holdoffDone &&
      (s.hist1 >= tLevel) && ((s.hist1 - tLevel) >= SLOPE_DROP);
    pulseOn = secCount < {4'h0, pulseCyc};
    tempOk = !hot && !cold;
  end

  // Next state, timers and outputs
  always_comb begin
    next_s = s;
    next_s.prevPresent = present;
    next_s.prevWake = wake;
    // Run the charge timer and sampling clock
    if (secTick && (s.state == mcs_pkg::FAST ||
        s.state == mcs_pkg::LICV || s.state == mcs_pkg::TOPOFF)) begin
      next_s.elapsed = s.elapsed + 16'h0001;
    end
    if (secTick && s.state == mcs_pkg::FAST) begin
      next_s.sampleSec = s.sampleSec + 4'h1;
    end
    // Shift temperature history at each sample
    if (sampleNow && s.state == mcs_pkg::FAST) begin
      next_s.hist1 = s.hist0;
      next_s.hist0 = tLevel;
      if (s.histCount != 2'd2) begin
        next_s.histCount = s.histCount + 2'd1;
      end
    end
    case (s.state)
      // Qualify voltage and temperature
      mcs_pkg::QUAL: begin
        if (present && batLow) begin
          next_s.state = mcs_pkg::PEND;
        end else if (present && tempOk) begin
          next_s.state = mcs_pkg::FAST;
        end
      end
      // Pulse-trickle a depleted pack
      mcs_pkg::PEND: begin
        if (!batLow && tempOk) begin
          next_s.state = mcs_pkg::FAST;
        end
      end
      // Constant current, chemistry decides the rest
      mcs_pkg::FAST: begin
        if (batMax) begin
          next_s.lithium = 1'b1;
          next_s.state = mcs_pkg::LICV;
          next_s.elapsed = 16'h0000;
        end else if (timeUp || cutoff || slopeTrip) begin
          next_s.elapsed = 16'h0000;
          if (s.lithium) begin
            next_s.state = mcs_pkg::LIDONE;
          end else if (topSel) begin
            next_s.state = mcs_pkg::TOPOFF;
          end else begin
            next_s.state = mcs_pkg::TRICKLE;
          end
        end
      end
      // Lithium constant voltage
      mcs_pkg::LICV: begin
        if (iMin || timeUp || cutoff) begin
          next_s.state = mcs_pkg::LIDONE;
        end
      end
      // Lithium finished, watch for depletion
      mcs_pkg::LIDONE: begin
        if (batRch) begin
          next_s.state = mcs_pkg::QUAL;
        end
      end
      // Nickel top-off for one max time
      mcs_pkg::TOPOFF: begin
        if (timeUp) begin
          next_s.state = mcs_pkg::TRICKLE;
        end
      end
      // Nickel maintenance
      mcs_pkg::TRICKLE: begin
        next_s.state = mcs_pkg::TRICKLE;
      end
      default: begin
        next_s.state = mcs_pkg::QUAL;
      end
    endcase
    // Any new cycle goes back to qualification
    if (restart || (s.state == mcs_pkg::LIDONE && batRch)) begin
      next_s.state = mcs_pkg::QUAL;
    end
    if (next_s.state == mcs_pkg::QUAL) begin
      next_s.lithium = `MCS_CHEM_RESET;
      next_s.elapsed = 16'h0000;
      next_s.sampleSec = 4'h0;
      next_s.histCount = 2'd0;
    end
    // Gate drive: high passes current
    case (s.state)
      mcs_pkg::PEND: begin
        next_s.gate = pulseOn && !hot;
      end
      mcs_pkg::FAST: begin
        next_s.gate = iLimit && tempOk;
      end
      mcs_pkg::LICV: begin
        next_s.gate = iLimit && !batMax;
      end
      mcs_pkg::TOPOFF: begin
        next_s.gate = iLimit && !batMax && !hot &&
          (secCount[`MCS_TOPOFF_DUTY_BITS-1:0] == '0);
      end
      mcs_pkg::TRICKLE: begin
        next_s.gate = pulseOn && !batMax && !hot;
      end
      default: begin
        next_s.gate = 1'b0;
      end
    endcase
    // Lamp: blink pending, on while charging
    case (s.state)
      mcs_pkg::PEND: begin
        next_s.lamp = secCount < HALF_SEC;
      end
      mcs_pkg::FAST, mcs_pkg::LICV, mcs_pkg::TOPOFF: begin
        next_s.lamp = 1'b1;
      end
      default: begin
        next_s.lamp = 1'b0;
      end
    endcase
  end

  // Register the whole state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign chargeGateOutput = s.gate;
  assign statusLampOutput = s.lamp;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_qual_blocks;
    s.state == mcs_pkg::QUAL |=> !chargeGateOutput;
  endproperty
  a_qual_blocks: assert property (p_qual_blocks)
    else $error("gate high after qualification");

  property p_low_pends;
    s.state == mcs_pkg::QUAL && present && batLow && !restart
      |=> s.state == mcs_pkg::PEND;
  endproperty
  a_low_pends: assert property (p_low_pends)
    else $error("low pack did not pend");

  property p_hot_no_trickle;
    s.state == mcs_pkg::PEND && hot |=> !chargeGateOutput;
  endproperty
  a_hot_no_trickle: assert property (p_hot_no_trickle)
    else $error("pulse trickle while hot");

  property p_start_fast;
    s.state == mcs_pkg::QUAL && present && !batLow && tempOk && !restart
      |=> s.state == mcs_pkg::FAST && s.lithium == 1'b0;
  endproperty
  a_start_fast: assert property (p_start_fast)
    else $error("valid pack did not start fast charge");

  property p_lithium_detect;
    s.state == mcs_pkg::FAST && batMax && !restart
      |=> s.state == mcs_pkg::LICV && s.lithium && s.elapsed == 16'h0000;
  endproperty
  a_lithium_detect: assert property (p_lithium_detect)
    else $error("lithium not detected");

  property p_min_current;
    s.state == mcs_pkg::LICV && iMin && !restart
      |=> s.state == mcs_pkg::LIDONE ##1 !chargeGateOutput;
  endproperty
  a_min_current: assert property (p_min_current)
    else $error("constant voltage did not end");

  property p_recharge;
    s.state == mcs_pkg::LIDONE && batRch |=> s.state == mcs_pkg::QUAL;
  endproperty
  a_recharge: assert property (p_recharge)
    else $error("no recharge restart");

  property p_no_topoff;
    s.state == mcs_pkg::FAST && !s.lithium && !batMax && timeUp &&
      !topSel && !restart |=> s.state == mcs_pkg::TRICKLE;
  endproperty
  a_no_topoff: assert property (p_no_topoff)
    else $error("top-off not skipped");

  property p_chem_held;
    s.state != mcs_pkg::QUAL && s.state != mcs_pkg::FAST
      ##1 s.state != mcs_pkg::QUAL |-> $stable(s.lithium);
  endproperty
  a_chem_held: assert property (p_chem_held)
    else $error("chemistry changed mid cycle");

  property p_lidone_off;
    s.state == mcs_pkg::LIDONE [*2] |-> !chargeGateOutput;
  endproperty
  a_lidone_off: assert property (p_lidone_off)
    else $error("lithium trickle after termination");

  c_pending: cover property (s.state == mcs_pkg::PEND ##1
    s.state == mcs_pkg::FAST);
  c_lithium: cover property (s.state == mcs_pkg::LICV ##1
    s.state == mcs_pkg::LIDONE);
  c_topoff: cover property (s.state == mcs_pkg::TOPOFF ##1
    s.state == mcs_pkg::TRICKLE);
endmodule : mcs_sequencer

/* verification/mcs_pack_model.sv */
`timescale 1ns/1ps
// Pack, thermistor and sense-resistor comparators seen by the sequencer
module mcs_pack_model #(
  parameter int LOW_MV = 950,
  parameter int RECHARGE_MV = 1900,
  parameter int MAX_MV = 2000,
  parameter logic [7:0] HOT_CODE = 8'h40,
  parameter logic [7:0] COLD_CODE = 8'hC0,
  parameter logic [7:0] CUTOFF_CODE = 8'h38,
  parameter int LIMIT_MA = 1000,
  parameter int MIN_MA = 70
) (
  input int packMv,
  input int currentMa,
  input wire logic [7:0] tempCode,
  output logic batteryBelowLowThreshold,
  output logic batteryAtMaxCellVoltage,
  output logic batteryBelowRechargeThreshold,
  output logic tempBelowHighFault,
  output logic tempAboveLowFault,
  output logic tempBelowCutoff,
  output logic currentBelowLimit,
  output logic currentBelowMinimum
);
  // Each threshold becomes one comparator flag
  assign batteryBelowLowThreshold = packMv < LOW_MV;
  assign batteryAtMaxCellVoltage = packMv >= MAX_MV;
  assign batteryBelowRechargeThreshold = packMv < RECHARGE_MV;
  // Thermistor voltage falls as the pack warms
  assign tempBelowHighFault = tempCode < HOT_CODE;
  assign tempAboveLowFault = tempCode > COLD_CODE;
  assign tempBelowCutoff = tempCode < CUTOFF_CODE;
  // Sense current against regulation and taper limits
  assign currentBelowLimit = currentMa < LIMIT_MA;
  assign currentBelowMinimum = currentMa < MIN_MA;
endmodule : mcs_pack_model

/* verification/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the charge sequencer
module tb;
  localparam int SEC = 64; // Cycles per scaled second
  localparam int LIMIT = 20000; // Timeout ceiling in cycles
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic batteryPresent = 1'b0;
  logic wakeUp = 1'b0;
  logic [7:0] tempCode = 8'h80; // Normal temperature
  int packMv = 1500;
  int currentMa = 500;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic topSel = 1'b0; // Top-off choice
  logic lowB, maxB, rchB, hotT, coldT, cutT, limI, minI;
  logic chargeGateOutput, statusLampOutput;
  // Clock at 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  // Far side comparators
  mcs_pack_model i_pack (.packMv(packMv), .currentMa(currentMa),
    .tempCode(tempCode), .batteryBelowLowThreshold(lowB),
    .batteryAtMaxCellVoltage(maxB), .batteryBelowRechargeThreshold(rchB),
    .tempBelowHighFault(hotT), .tempAboveLowFault(coldT),
    .tempBelowCutoff(cutT), .currentBelowLimit(limI),
    .currentBelowMinimum(minI));
  // Block under test, short second for simulation
  mcs_sequencer #(.ONE_SEC_CYCLES(SEC)) i_dut (.sys_clk(sys_clk),
    .rstn(rstn), .batteryPresent(batteryPresent), .wakeUp(wakeUp),
    .batteryBelowLowThreshold(lowB), .batteryAtMaxCellVoltage(maxB),
    .batteryBelowRechargeThreshold(rchB), .tempBelowHighFault(hotT),
    .tempAboveLowFault(coldT), .tempBelowCutoff(cutT),
    .currentBelowLimit(limI), .currentBelowMinimum(minI),
    .temperatureLevel(tempCode), .maxChargeSeconds(16'h0028),
    .tricklePulseCycles(24'h00_000A), .topOffSelect(topSel),
    .chargeGateOutput(chargeGateOutput),
    .statusLampOutput(statusLampOutput));
  // Verdict and end of run
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end
  // Wait on falling edges, where inputs change
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cycles
  // Compare one output level
  task automatic check_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: %s got %b", $time, m, got);
    end
  endtask : check_bit
  // Compare a count of high cycles
  task automatic check_int(input int got, input int exp, input string m);
    cmp_count++;
    if (got != exp) begin
      err_count++;
      $display("ERROR %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : check_int
  // Count gate and lamp high cycles over a window
  task automatic count_high(input int n, output int g, output int l);
    g = 0;
    l = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (chargeGateOutput === 1'b1) g++;
      if (statusLampOutput === 1'b1) l++;
    end
  endtask : count_high
  // Pack swap restarts the cycle
  task automatic swap_pack();
    batteryPresent = 1'b0;
    wait_cycles(6);
    batteryPresent = 1'b1;
    wait_cycles(10);
  endtask : swap_pack
  // Inserted pack qualifies, gate follows sense current
  task automatic t_fast();
    batteryPresent = 1'b1;
    wait_cycles(10);
    check_bit(chargeGateOutput, 1'b1, "gate in fast");
    check_bit(statusLampOutput, 1'b1, "lamp in fast");
    currentMa = 1500;
    wait_cycles(6);
    check_bit(chargeGateOutput, 1'b0, "gate over limit");
    currentMa = 500;
    wait_cycles(6);
    check_bit(chargeGateOutput, 1'b1, "gate under limit");
    $display("t_fast done");
  endtask : t_fast
  // Depleted pack pulses and blinks; heat stops the pulses, cold holds off fast charge
  task automatic t_pending();
    int g, l;
    packMv = 500;
    swap_pack();
    count_high(2 * SEC, g, l);
    check_int(g, 20, "pending pulses");
    check_int(l, SEC, "pending blink");
    tempCode = 8'h3C;
    wait_cycles(10);
    count_high(2 * SEC, g, l);
    check_int(g, 0, "hot trickle");
    tempCode = 8'hC8;
    packMv = 1500;
    wait_cycles(10);
    count_high(2 * SEC, g, l);
    check_int(g, 20, "cold keeps pulse trickle");
    check_int(l, SEC, "cold stays pending");
    tempCode = 8'h80;
    wait_cycles(10);
    check_bit(chargeGateOutput, 1'b1, "valid pack charges");
    $display("t_pending done");
  endtask : t_pending
  // Nickel times out, skips top-off, trickles below max voltage
  task automatic t_nickel();
    int g, l;
    wait_cycles(40 * SEC + 100);
    count_high(SEC, g, l);
    check_int(g, 10, "nickel trickle");
    packMv = 2000;
    wait_cycles(10);
    count_high(2 * SEC, g, l);
    check_int(g, 0, "trickle at max voltage");
    packMv = 1500;
    $display("t_nickel done");
  endtask : t_nickel
  // Lithium two phases, taper end, recharge restart
  task automatic t_lithium();
    int g, l;
    wakeUp = 1'b1;
    wait_cycles(10);
    wakeUp = 1'b0;
    check_bit(chargeGateOutput, 1'b1, "wake restarts charge");
    packMv = 2000;
    wait_cycles(10);
    check_bit(chargeGateOutput, 1'b0, "gate at max voltage");
    check_bit(statusLampOutput, 1'b1, "lamp in voltage phase");
    packMv = 1990;
    wait_cycles(10);
    check_bit(chargeGateOutput, 1'b1, "voltage phase below max");
    currentMa = 50;
    wait_cycles(10);
    count_high(2 * SEC, g, l);
    check_int(g, 0, "taper end, no trickle");
    packMv = 1800;
    wait_cycles(12);
    check_bit(chargeGateOutput, 1'b1, "recharge restart");
    $display("t_lithium done");
  endtask : t_lithium
  // Nickel top-off at one sixteenth duty, then trickle
  task automatic t_topoff();
    int g, l;
    topSel = 1'b1;
    wait_cycles(40 * SEC + 100);
    count_high(SEC, g, l);
    check_int(g, 4, "top-off duty");
    check_int(l, SEC, "lamp in top-off");
    wait_cycles(40 * SEC + 100);
    count_high(SEC, g, l);
    check_int(g, 10, "trickle after top-off");
    check_int(l, 0, "lamp in trickle");
    $display("t_topoff done");
  endtask : t_topoff
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    t_fast();
    t_pending();
    t_nickel();
    t_lithium();
    t_topoff();
    print_verdict();
  end
endmodule : tb
